// >>> logic/slm_i2c_slave.sv
/*
 Two-wire bus slave for the signal level monitor: start/stop detection,
 device address match, subaddress with auto-increment, writes and reads.
 Assumes bus clock well below core_clk/8 and open-drain SDA resolved
 outside; sda_oe high pulls SDA low.
*/
`timescale 1ns/100ps
`default_nettype none

module slm_i2c_slave (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic addr_sel_in,
   input wire logic [7:0] rd_data,
   output logic [7:0] rd_addr,
   output slm_pkg::slm_wr_t wr,
   output logic sda_oe
);

   logic scl_m_reg, scl_s_reg, scl_d_reg;
   logic sda_m_reg, sda_s_reg, sda_d_reg;
   logic sel_m_reg, sel_s_reg;
   slm_pkg::slm_bus_state_t state_reg, state_next;
   logic [3:0] cnt_reg, cnt_next;
   logic [7:0] sh_reg, sh_next, tx_reg, tx_next, ptr_reg, ptr_next;
   logic oe_reg, oe_next;
   slm_pkg::slm_wr_t wr_reg, wr_next;
   logic rise, fall, start, stop;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         scl_m_reg <= 1'b1;
         scl_s_reg <= 1'b1;
         scl_d_reg <= 1'b1;
         sda_m_reg <= 1'b1;
         sda_s_reg <= 1'b1;
         sda_d_reg <= 1'b1;
         sel_m_reg <= 1'b0;
         sel_s_reg <= 1'b0;
      end else begin
         scl_m_reg <= scl_in;
         scl_s_reg <= scl_m_reg;
         scl_d_reg <= scl_s_reg;
         sda_m_reg <= sda_in;
         sda_s_reg <= sda_m_reg;
         sda_d_reg <= sda_s_reg;
         sel_m_reg <= addr_sel_in;
         sel_s_reg <= sel_m_reg;
      end
   end

   assign rise = scl_s_reg & ~scl_d_reg;
   assign fall = ~scl_s_reg & scl_d_reg;
   assign start = scl_s_reg & scl_d_reg & sda_d_reg & ~sda_s_reg;
   assign stop = scl_s_reg & scl_d_reg & ~sda_d_reg & sda_s_reg;

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      sh_next = sh_reg;
      tx_next = tx_reg;
      ptr_next = ptr_reg;
      oe_next = oe_reg;
      wr_next = wr_reg;
      wr_next.strobe = 1'b0;
      // Start or stop anywhere drops the transfer in progress
      if (stop) begin // see R10
         state_next = slm_pkg::SLM_IDLE;
         oe_next = 1'b0;
      end else if (start) begin
         state_next = slm_pkg::SLM_DEV;
         cnt_next = 4'h0;
         oe_next = 1'b0;
      end else if (state_reg != slm_pkg::SLM_IDLE) begin
         if (rise) begin
            if (cnt_reg < slm_pkg::BITS_PER_BYTE) begin
               sh_next = {sh_reg[6:0], sda_s_reg};
               cnt_next = cnt_reg + 4'h1;
            end else if (state_reg == slm_pkg::SLM_RD && sda_s_reg) begin
               state_next = slm_pkg::SLM_IDLE;
            end
         end else if (fall) begin
            if (cnt_reg < slm_pkg::BITS_PER_BYTE) begin
               if (state_reg == slm_pkg::SLM_RD) begin
                  oe_next = ~tx_reg[7];
                  tx_next = {tx_reg[6:0], 1'b0};
               end
            end else if (cnt_reg == slm_pkg::BITS_PER_BYTE) begin
               cnt_next = slm_pkg::ACK_PHASE;
               oe_next = 1'b0;
               case (state_reg)
                  slm_pkg::SLM_DEV: begin // see R10
                     if (sh_reg[7:1] ==
                         {slm_pkg::SLV_ADDR_HI, sel_s_reg}) begin
                        oe_next = 1'b1;
                        state_next = sh_reg[0] ? slm_pkg::SLM_RD :
                                                 slm_pkg::SLM_SUB;
                     end else begin
                        state_next = slm_pkg::SLM_IDLE;
                     end
                  end
                  slm_pkg::SLM_SUB: begin
                     if (slm_pkg::slm_valid_sub(sh_reg)) begin
                        oe_next = 1'b1;
                        ptr_next = sh_reg;
                        state_next = slm_pkg::SLM_WR;
                     end else begin
                        state_next = slm_pkg::SLM_IDLE;
                     end
                  end
                  slm_pkg::SLM_WR: begin // see R10
                     oe_next = 1'b1;
                     wr_next.strobe = 1'b1;
                     wr_next.addr = ptr_reg;
                     wr_next.data = sh_reg;
                     ptr_next = slm_pkg::slm_next_ptr(ptr_reg);
                  end
                  default: begin
                  end
               endcase
            end else begin
               cnt_next = 4'h0;
               oe_next = 1'b0;
               if (state_reg == slm_pkg::SLM_RD) begin
                  oe_next = ~rd_data[7];
                  tx_next = {rd_data[6:0], 1'b0};
                  ptr_next = slm_pkg::slm_next_ptr(ptr_reg);
               end
            end
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= slm_pkg::SLM_IDLE;
         cnt_reg <= 4'h0;
         sh_reg <= 8'h00;
         tx_reg <= 8'h00;
         ptr_reg <= 8'h00;
         oe_reg <= 1'b0;
         wr_reg <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         sh_reg <= sh_next;
         tx_reg <= tx_next;
         ptr_reg <= ptr_next;
         oe_reg <= oe_next;
         wr_reg <= wr_next;
      end
   end

   assign rd_addr = ptr_reg;
   assign wr = wr_reg;
   assign sda_oe = oe_reg;

   stop_to_idle_a: assert property (@(posedge core_clk) // see R10
      disable iff (!nrst)
      stop |=> state_reg == slm_pkg::SLM_IDLE && !oe_reg)
      else $error("stop did not return bus to idle");

   wr_single_a: assert property (@(posedge core_clk) // see R10
      disable iff (!nrst)
      wr_reg.strobe |=> !wr_reg.strobe ##1 !wr_reg.strobe)
      else $error("write strobe longer than one cycle");

   bad_sub_nack_a: assert property (@(posedge core_clk) // see R10
      disable iff (!nrst)
      state_reg == slm_pkg::SLM_SUB && fall && !stop && !start &&
      cnt_reg == slm_pkg::BITS_PER_BYTE && !slm_pkg::slm_valid_sub(sh_reg)
      |=> !oe_reg && state_reg == slm_pkg::SLM_IDLE)
      else $error("invalid subaddress was acknowledged");

endmodule

`default_nettype wire

// >>> logic/slm_monitor.sv
/*
 Signal level monitor control: level registers behind the two-wire bus,
 threshold programming, single-shot amplitude capture and the hysteretic
 signal-absent flag.
 Assumes level_in is the digitized absolute peak-to-peak amplitude in mV
 from the analog front end, asynchronous and slowly changing.
*/
// Operation
// R1: Flag sets below threshold, clears only at twice the threshold.
// R2: Level measured absolutely; slice offset code never enters the compare.
// R3: Monitor on after reset; control bit 3 at 0x9 powers it down.
// R4: Threshold 0..128 mV taken from level value on strobe with target 1.
// R5: Host writes 0x21, threshold, 0x31, 0x21 to program threshold.
// R6: Threshold above 63 drops bit 0, giving 2 mV steps.
// R7: Host writes 0x7, 0x17, 0x7 to take one measurement.
// R8: Strobe falling with target 7 loads measured amplitude into level value.
// R9: Level value changes only after low-high-low strobe at target 7; the code also loads it on a host write to 0x36.
// R10: Two-wire bus: device address, subaddress, auto-incrementing data bytes.
// R11: Level value reads last capture or last host write.
`timescale 1ns/100ps
`default_nettype none

module slm_monitor (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic addr_sel_in,
   input wire logic [7:0] level_in,
   output logic signal_absent_flag,
   output logic monitor_powerdown,
   output logic [7:0] threshold_mv
);

   logic [7:0] ctrl_reg, ctrl_next;
   logic [7:0] level_value_reg, level_value_next;
   logic [7:0] level_access_control_reg, level_access_control_next;
   logic [7:0] thresh_reg, thresh_next;
   logic armed_reg, armed_next;
   logic flag_reg, flag_next;
   logic [7:0] lvl_m_reg, lvl_s_reg;
   logic [7:0] rd_addr, rd_data;
   slm_pkg::slm_wr_t wr;
   logic acc_wr, stb_rise, stb_fall, pdn;
   logic [2:0] tgt;

   // Coarse range keeps only even codes; anything above full scale clamps
   function automatic logic [7:0] slm_quantize(input logic [7:0] v);
      if (v > slm_pkg::THRESH_MAX) begin
         slm_quantize = slm_pkg::THRESH_MAX;
      end else if (v > slm_pkg::THRESH_FINE_TOP) begin
         slm_quantize = {v[7:1], 1'b0};
      end else begin
         slm_quantize = v;
      end
   endfunction

   slm_i2c_slave u_bus (
      .core_clk(core_clk),
      .nrst(nrst),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .addr_sel_in(addr_sel_in),
      .rd_data(rd_data),
      .rd_addr(rd_addr),
      .wr(wr),
      .sda_oe(sda_oe)
   );

   // Multi-bit level is quasi-static; a torn sample only lasts one cycle
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         lvl_m_reg <= 8'h00;
         lvl_s_reg <= 8'h00;
      end else begin
         lvl_m_reg <= level_in;
         lvl_s_reg <= lvl_m_reg;
      end
   end

   always_comb begin
      case (rd_addr)
         slm_pkg::ADDR_CTRL: rd_data = ctrl_reg;
         slm_pkg::ADDR_LEVEL: rd_data = level_value_reg; // see R11
         slm_pkg::ADDR_ACCESS: rd_data = level_access_control_reg;
         default: rd_data = 8'h00;
      endcase
   end

   assign pdn = ctrl_reg[slm_pkg::PDN_BIT];
   assign acc_wr = wr.strobe && wr.addr == slm_pkg::ADDR_ACCESS;
   assign tgt = wr.data[slm_pkg::TGT_MSB:0];
   assign stb_rise = acc_wr &&
                     !level_access_control_reg[slm_pkg::STROBE_BIT] &&
                     wr.data[slm_pkg::STROBE_BIT];
   assign stb_fall = acc_wr &&
                     level_access_control_reg[slm_pkg::STROBE_BIT] &&
                     !wr.data[slm_pkg::STROBE_BIT];

   always_comb begin
      ctrl_next = ctrl_reg;
      level_value_next = level_value_reg;
      level_access_control_next = level_access_control_reg;
      thresh_next = thresh_reg;
      armed_next = armed_reg;
      if (wr.strobe && wr.addr == slm_pkg::ADDR_CTRL) begin
         ctrl_next = wr.data; // see R3
      end
      if (wr.strobe && wr.addr == slm_pkg::ADDR_LEVEL) begin
         level_value_next = wr.data; // see R11
      end
      if (acc_wr) begin
         level_access_control_next = wr.data;
         // Target must stay 7 from the rising strobe write through the falling one
         if (tgt != slm_pkg::TGT_MEASURE) begin
            armed_next = 1'b0; // see R9
         end else if (stb_rise) begin
            armed_next = 1'b1; // see R9
         end
         if (stb_rise && tgt == slm_pkg::TGT_THRESH) begin
            thresh_next = slm_quantize(level_value_reg); // see R4 see R6
         end
         if (stb_fall && tgt == slm_pkg::TGT_MEASURE && armed_reg) begin
            // A powered-down monitor has no amplitude to report
            level_value_next = pdn ? 8'h00 : lvl_s_reg; // see R8 see R9
            armed_next = 1'b0;
         end
      end
   end

   // Absolute level only: no slice code reaches this compare (see R2)
   always_comb begin
      flag_next = flag_reg;
      if (pdn) begin
         flag_next = 1'b0; // see R3
      end else if (!flag_reg && lvl_s_reg < thresh_reg) begin
         flag_next = 1'b1; // see R1
      end else if (flag_reg && {1'b0, lvl_s_reg} >= {thresh_reg, 1'b0}) begin
         flag_next = 1'b0; // see R1
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_reg <= slm_pkg::CTRL_RST;
         level_value_reg <= slm_pkg::LEVEL_RST;
         level_access_control_reg <= slm_pkg::ACCESS_RST;
         thresh_reg <= slm_pkg::THRESH_RST;
         armed_reg <= 1'b0;
         flag_reg <= 1'b0;
      end else begin
         ctrl_reg <= ctrl_next;
         level_value_reg <= level_value_next;
         level_access_control_reg <= level_access_control_next;
         thresh_reg <= thresh_next;
         armed_reg <= armed_next;
         flag_reg <= flag_next;
      end
   end

   assign sda_out = 1'b0;
   assign signal_absent_flag = flag_reg;
   assign monitor_powerdown = ctrl_reg[slm_pkg::PDN_BIT];
   assign threshold_mv = thresh_reg;

   thresh_capture_a: assert property (@(posedge core_clk) // see R4
      disable iff (!nrst)
      stb_rise && tgt == slm_pkg::TGT_THRESH
      |=> thresh_reg == slm_quantize($past(level_value_reg)))
      else $error("threshold not captured on strobe");

   thresh_hold_a: assert property (@(posedge core_clk) // see R4
      disable iff (!nrst)
      !(stb_rise && tgt == slm_pkg::TGT_THRESH) |=> $stable(thresh_reg))
      else $error("threshold changed without strobe");

   coarse_step_a: assert property (@(posedge core_clk) // see R6
      disable iff (!nrst)
      thresh_reg > slm_pkg::THRESH_FINE_TOP
      |-> !thresh_reg[0] && thresh_reg <= slm_pkg::THRESH_MAX)
      else $error("coarse threshold has odd code or exceeds range");

   meas_load_a: assert property (@(posedge core_clk) // see R8
      disable iff (!nrst)
      stb_fall && tgt == slm_pkg::TGT_MEASURE && armed_reg && !pdn
      |=> level_value_reg == $past(lvl_s_reg))
      else $error("measurement not loaded on strobe fall");

   level_stable_a: assert property (@(posedge core_clk) // see R9
      disable iff (!nrst)
      !(wr.strobe && wr.addr == slm_pkg::ADDR_LEVEL) &&
      !(stb_fall && armed_reg && tgt == slm_pkg::TGT_MEASURE)
      |=> $stable(level_value_reg))
      else $error("level value changed without cause");

   flag_set_a: assert property (@(posedge core_clk) // see R1
      disable iff (!nrst)
      !pdn && !flag_reg && lvl_s_reg < thresh_reg |=> flag_reg)
      else $error("flag did not set below threshold");

   flag_hyst_a: assert property (@(posedge core_clk) // see R1
      disable iff (!nrst)
      !pdn && flag_reg && {1'b0, lvl_s_reg} < {thresh_reg, 1'b0}
      |=> flag_reg)
      else $error("flag cleared below twice the threshold");

   flag_clear_a: assert property (@(posedge core_clk) // see R1
      disable iff (!nrst)
      !pdn && flag_reg && {1'b0, lvl_s_reg} >= {thresh_reg, 1'b0}
      |=> !flag_reg)
      else $error("flag stuck at twice the threshold");

   pdn_flag_a: assert property (@(posedge core_clk) // see R3
      disable iff (!nrst)
      pdn |=> !flag_reg)
      else $error("flag active while powered down");

endmodule

`default_nettype wire

// >>> logic/slm_pkg.sv
/*
 Shared constants and types for the signal level monitor: register
 subaddresses, field positions, reset values, bus states and carriers.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package slm_pkg;

   // Fixed upper six bits of the 7-bit bus address
   localparam logic [5:0] SLV_ADDR_HI = 6'h20;

   localparam logic [7:0] ADDR_CTRL = 8'h09;
   localparam logic [7:0] ADDR_LEVEL = 8'h36;
   localparam logic [7:0] ADDR_ACCESS = 8'h74;

   localparam int PDN_BIT = 3;
   localparam int STROBE_BIT = 4;
   localparam int TGT_MSB = 2;

   localparam logic [2:0] TGT_THRESH = 3'h1;
   localparam logic [2:0] TGT_MEASURE = 3'h7;

   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] LEVEL_RST = 8'h00;
   localparam logic [7:0] ACCESS_RST = 8'h00;
   localparam logic [7:0] THRESH_RST = 8'h00;

   localparam logic [7:0] THRESH_MAX = 8'h80;
   localparam logic [7:0] THRESH_FINE_TOP = 8'h3F;

   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] ACK_PHASE = 4'h9;

   typedef enum logic [2:0] {
      SLM_IDLE = 3'h0,
      SLM_DEV = 3'h1,
      SLM_SUB = 3'h3,
      SLM_WR = 3'h2,
      SLM_RD = 3'h6
   } slm_bus_state_t;

   typedef struct packed {
      logic strobe;
      logic [7:0] addr;
      logic [7:0] data;
   } slm_wr_t;

   function automatic logic slm_valid_sub(input logic [7:0] a);
      slm_valid_sub = (a == ADDR_CTRL) || (a == ADDR_LEVEL) ||
                      (a == ADDR_ACCESS);
   endfunction

   // Highest subaddress repeats once reached
   function automatic logic [7:0] slm_next_ptr(input logic [7:0] a);
      slm_next_ptr = (a == ADDR_ACCESS) ? a : a + 8'h01;
   endfunction

endpackage

`default_nettype wire

// >>> tb/slm_host.sv
/*
 Host model for the signal level monitor: a bit-banged two-wire bus
 master with register write, register read and level helper sequences.
 Assumes the bench resolves SDA with a pull-up from sda_low and the
 device's drive, and that tasks are entered just after a falling edge
 of a 100 ns core clock, so every change stays off the rising edge.
*/
`timescale 1ns/100ps
`default_nettype none

module slm_host #(
   parameter logic SEL = 1'b1
) (
   output logic scl,
   output logic sda_low,
   input wire logic sda
);
   // Quarter bus period; 20 core clocks per bit keeps the slave's sync happy
   localparam int Q = 500;

   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   task automatic bit_out(input logic b);
      sda_low = !b;
      #(Q);
      scl = 1'b1;
      #(2*Q);
      scl = 1'b0;
      #(Q);
   endtask

   task automatic bit_in(output logic b);
      sda_low = 1'b0;
      #(Q);
      scl = 1'b1;
      #(Q);
      b = sda;
      #(Q);
      scl = 1'b0;
      #(Q);
   endtask

   task automatic start();
      sda_low = 1'b0;
      #(Q);
      scl = 1'b1;
      #(Q);
      sda_low = 1'b1;
      #(Q);
      scl = 1'b0;
      #(Q);
   endtask

   task automatic stop();
      sda_low = 1'b1;
      #(Q);
      scl = 1'b1;
      #(Q);
      sda_low = 1'b0;
      #(Q);
   endtask

   // MSB first, then the slave's acknowledge bit
   task automatic send(input logic [7:0] d, inout logic ok);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         bit_out(d[i]);
      end
      bit_in(b);
      ok = ok & !b;
   endtask

   task automatic wr(input logic [7:0] sub, input logic [23:0] d,
                     input int n, output logic ok);
      ok = 1'b1;
      start();
      send({6'h20, SEL, 1'b0}, ok);
      send(sub, ok);
      for (int i = 0; i < n; i++) begin
         send(d[23-8*i -: 8], ok);
      end
      stop();
   endtask

   task automatic rd(input logic [7:0] sub, output logic [7:0] d,
                     output logic ok);
      ok = 1'b1;
      start();
      send({6'h20, SEL, 1'b0}, ok);
      send(sub, ok);
      start();
      send({6'h20, SEL, 1'b1}, ok);
      for (int i = 7; i >= 0; i--) begin
         bit_in(d[i]);
      end
      bit_out(1'b1);
      stop();
   endtask

   // Control byte repeats at the top subaddress, so one burst suffices
   task automatic prog(input logic [7:0] v, output logic ok);
      logic a;
      logic b;
      wr(8'h74, 24'h210000, 1, a);
      wr(8'h36, {v, 16'h0000}, 1, b);
      wr(8'h74, 24'h312100, 2, ok);
      ok = ok & a & b;
   endtask

   task automatic measure(output logic ok);
      wr(8'h74, 24'h071707, 3, ok);
   endtask
endmodule

`default_nettype wire

// >>> tb/testbench.sv
/*
 Self-checking bench for the signal level monitor top module.
 Assumes the host model drives the bus and that level_in is applied
 directly; the address strap is high except inside the bus scenario.
*/
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
 fail_count++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end

module testbench;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] level_in = 8'h00;
   logic addr_sel = 1'b1;
   logic scl;
   logic sda_low;
   logic sda_out;
   logic sda_oe;
   logic flag;
   logic pdn;
   logic [7:0] thr;
   int fail_count = 0;
   int n_tests = 0;
   wire logic sda = !(sda_low | (sda_oe & !sda_out));

   // Seven threshold codes, first in the top byte
   localparam logic [55:0] THR_IN = 56'h283F40417F80C8;
   localparam logic [55:0] THR_EXP = 56'h283F40407E8080;

   always #50 core_clk = ~core_clk;

   slm_host #(.SEL(1'b1)) i_slm_host (.scl(scl), .sda_low(sda_low),
      .sda(sda));

   slm_monitor i_slm_monitor (.core_clk(core_clk), .nrst(nrst),
      .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
      .addr_sel_in(addr_sel), .level_in(level_in),
      .signal_absent_flag(flag), .monitor_powerdown(pdn),
      .threshold_mv(thr));

   task automatic print_verdict();
      if (fail_count == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic w(input logic [7:0] sub, input logic [23:0] d, int n);
      logic ok;
      i_slm_host.wr(sub, d, n, ok);
      `CHK("wr_ack", 1'b1, ok)
   endtask

   task automatic chk_reg(input logic [7:0] sub, input logic [7:0] e);
      logic [7:0] d;
      logic ok;
      i_slm_host.rd(sub, d, ok);
      `CHK("rd_ack", 1'b1, ok)
      `CHK("reg", e, d)
   endtask

   task automatic settle(input logic [7:0] lv);
      level_in = lv;
      repeat (6) @(negedge core_clk);
   endtask

   task automatic t_reset();
      `CHK("flag", 1'b0, flag)
      `CHK("pdn", 1'b0, pdn)
      `CHK("thr_rst", 8'h00, thr)
      `CHK("sda_out", 1'b0, sda_out)
      chk_reg(8'h09, 8'h00);
      chk_reg(8'h36, 8'h00);
      chk_reg(8'h74, 8'h00);
   endtask

   task automatic t_thresh();
      logic ok;
      for (int i = 0; i < 7; i++) begin
         i_slm_host.prog(THR_IN[55-8*i -: 8], ok);
         `CHK("prog_ack", 1'b1, ok)
         `CHK("thr", THR_EXP[55-8*i -: 8], thr)
      end
      // Strobe toggled with a target other than 1 must not capture
      w(8'h36, 24'h0A0000, 1);
      w(8'h74, 24'h223222, 3);
      `CHK("thr_hold", 8'h80, thr)
      i_slm_host.prog(8'h28, ok);
      `CHK("thr", 8'h28, thr)
   endtask

   task automatic t_hyst();
      settle(8'h27);
      `CHK("flag_set", 1'b1, flag)
      settle(8'h4F);
      `CHK("flag_hold", 1'b1, flag)
      settle(8'h50);
      `CHK("flag_clr", 1'b0, flag)
      settle(8'h28);
      `CHK("flag_edge", 1'b0, flag)
      settle(8'h27);
      `CHK("flag_set2", 1'b1, flag)
   endtask

   task automatic t_meas();
      logic ok;
      settle(8'h5A);
      i_slm_host.measure(ok);
      `CHK("meas_ack", 1'b1, ok)
      chk_reg(8'h36, 8'h5A);
      chk_reg(8'h74, 8'h07);
      w(8'h36, 24'h110000, 1);
      chk_reg(8'h36, 8'h11);
      settle(8'h33);
      // Falling strobe after the target moved away must not load
      w(8'h74, 24'h170500, 2);
      chk_reg(8'h36, 8'h11);
      i_slm_host.measure(ok);
      chk_reg(8'h36, 8'h33);
   endtask

   task automatic t_pdn();
      logic ok;
      settle(8'h20);
      `CHK("flag_low", 1'b1, flag)
      w(8'h09, 24'h080000, 1);
      `CHK("pdn_on", 1'b1, pdn)
      `CHK("flag_pd", 1'b0, flag)
      chk_reg(8'h09, 8'h08);
      i_slm_host.measure(ok);
      chk_reg(8'h36, 8'h00);
      w(8'h09, 24'h000000, 1);
      repeat (6) @(negedge core_clk);
      `CHK("pdn_off", 1'b0, pdn)
      `CHK("flag_back", 1'b1, flag)
   endtask

   task automatic t_bus();
      logic ok;
      ok = 1'b1;
      i_slm_host.start();
      i_slm_host.send(8'h40, ok);
      i_slm_host.stop();
      `CHK("bad_dev", 1'b0, ok)
      i_slm_host.wr(8'h10, 24'h550000, 1, ok);
      `CHK("bad_sub", 1'b0, ok)
      // Strap low moves the device off the host's address
      addr_sel = 1'b0;
      repeat (4) @(negedge core_clk);
      i_slm_host.wr(8'h74, 24'h550000, 1, ok);
      `CHK("bad_sel", 1'b0, ok)
      addr_sel = 1'b1;
      repeat (4) @(negedge core_clk);
      chk_reg(8'h74, 8'h07);
   endtask

   initial begin
      repeat (5) @(negedge core_clk);
      nrst = 1'b1;
      repeat (5) @(negedge core_clk);
      t_reset();
      t_thresh();
      t_hyst();
      t_meas();
      t_pdn();
      t_bus();
      print_verdict();
   end

   // Hang guard, well above the full sequence length
   initial begin
      #(8_000_000);
      fail_count++;
      print_verdict();
   end
endmodule

`default_nettype wire
